// >>> bench/gate_driver_model.sv
// Gate driver model that measures every high pulse on the PWM pins.
`timescale 1ns/1ps
module gate_driver_model
	import rsp_timer_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// PWM pins
	input wire pwm_pins_s pwm_pins,
	// Last complete high width per pin, msb first
	output logic [6:0][15:0] high_len
);
	logic [6:0][15:0] run_len;
	// A driver sees levels only; widths are counted in pclk cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_len <= '0;
			high_len <= '0;
		end else begin
			for (int i = 0; i < 7; i++) begin
				if (pwm_pins[i]) begin
					run_len[i] <= run_len[i] + 16'h0001;
				end else begin
					run_len[i] <= 16'h0000;
					if (run_len[i] != 16'h0000) begin
						high_len[i] <= run_len[i];
					end
				end
			end
		end
	end
endmodule : gate_driver_model

// >>> bench/reset_sync_pwm_timer_test.sv
// Self-checking bench for the reset-synchronous PWM timer.
`timescale 1ns/1ps
module reset_sync_pwm_timer_test
	import rsp_timer_pkg::*;
();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, ext_drv;
	logic timer_clock_enable, osc_freq_select_bit, ihs_div_by_two, pin_a_out, pin_a_oe, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [1:0] osc_freq_code;
	wire logic pin_a_in;
	pwm_pins_s pwm_pins;
	logic [6:0][15:0] high_len;
	int n_errors = 0;
	int compares = 0;
	// Shared pin: timer drives it when enabled, else the bench does
	assign pin_a_in = pin_a_oe ? pin_a_out : ext_drv;

	reset_sync_pwm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_clock_enable(timer_clock_enable),
		.osc_freq_select_bit(osc_freq_select_bit), .osc_freq_code(osc_freq_code),
		.ihs_div_by_two(ihs_div_by_two), .pin_a_ch0_in(pin_a_in), .pin_a_ch0_out(pin_a_out),
		.pin_a_ch0_oe(pin_a_oe), .pwm_pins(pwm_pins), .irq(irq));
	gate_driver_model drv (.pclk(pclk), .presetn(presetn), .pwm_pins(pwm_pins),
		.high_len(high_len));

	// ==========================================================
	// Shared tasks
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer; ends with an idle edge so the next setup never collides
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			report_and_stop();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task automatic do_reset(input logic s, input logic [1:0] c);
		presetn <= 1'b0;
		osc_freq_select_bit <= s;
		osc_freq_code <= c;
		cyc(8);
		presetn <= 1'b1;
		cyc(2);
	endtask : do_reset

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		check(ihs_div_by_two, 1);
		apb(0, OFS_PERIOD, 0);
		check(rdata, 32'h0000FFFF);
		apb(0, OFS_INFO, 0);
		check(rdata[1:0], 2'b11);
		apb(1, 12'h030, 32'h00000001);
		check(rerr, 1);
	endtask : t_reset
	task automatic t_wave();
		timer_clock_enable <= 1'b1;
		apb(1, OFS_PERIOD, 9);
		apb(1, OFS_DUTY1, 3);
		apb(1, OFS_DUTY2, 5);
		apb(1, OFS_DUTY3, 0);
		apb(1, OFS_START, 3);
		cyc(40);
		check(high_len[6], 6);
		check(high_len[4], 6);
		check(high_len[5], 10);
		check({high_len[3], high_len[1]}, {16'd4, 16'd4});
		check({high_len[2], high_len[0]}, {16'd9, 16'd9});
		apb(1, OFS_FUNC, 3);
		apb(1, OFS_START, 2);
		cyc(3);
		check(pwm_pins, 7'h7F);
	endtask : t_wave
	task automatic t_selfstop();
		apb(1, OFS_FUNC, 2);
		apb(1, OFS_PERIOD, 40);
		apb(1, OFS_START, 1);
		apb(1, OFS_START, 0);
		apb(0, OFS_START, 0);
		check(rdata[1:0], 2'b01);
		cyc(50);
		apb(0, OFS_START, 0);
		check(rdata[0], 0);
		apb(0, OFS_COUNT, 0);
		check(rdata, 0);
		check(pwm_pins, 7'h13);
	endtask : t_selfstop
	task automatic t_irq();
		apb(0, OFS_STATUS, 0);
		check(rdata, 32'h0000000F);
		apb(1, OFS_MASK, 1);
		cyc(1);
		check(irq, 1);
		apb(1, OFS_STATUS, 32'h0000001F);
		cyc(1);
		check(irq, 0);
		apb(1, OFS_MASK, 32'h00000010);
		apb(1, OFS_PERIOD, 10);
		apb(1, OFS_START, 3);
		apb(1, OFS_COUNT, 32'h0000FFFD);
		cyc(6);
		check(irq, 1);
		apb(0, OFS_STATUS, 0);
		check(rdata[4], 1);
		apb(1, OFS_START, 2);
	endtask : t_irq
	task automatic t_ext();
		apb(1, OFS_PERIOD, 32'h0000FFFF);
		apb(1, OFS_CLKSEL, SRC_EXT);
		apb(1, OFS_PORT, 3);
		apb(1, OFS_COUNT, 0);
		apb(1, OFS_START, 3);
		repeat (5) begin
			cyc(3);
			ext_drv <= 1'b1;
			cyc(3);
			ext_drv <= 1'b0;
		end
		cyc(4);
		check(pin_a_oe, 0);
		apb(0, OFS_COUNT, 0);
		check(rdata, 5);
		apb(1, OFS_START, 2);
		apb(1, OFS_CLKSEL, SRC_SYSTEM_CLOCK);
		apb(1, OFS_PORT, 3);
		cyc(3);
		check({pin_a_oe, pin_a_out}, 2'b11);
		apb(0, OFS_PORT, 0);
		check(rdata[2:0], 3'b111);
	endtask : t_ext
	// Counts over 32 edges while running; the prescaler phase cannot change that count
	task automatic rate(input logic [2:0] src, input logic [31:0] exp);
		apb(1, OFS_CLKSEL, {29'h0, src});
		apb(1, OFS_COUNT, 0);
		cyc(31);
		apb(0, OFS_COUNT, 0);
		check(rdata, exp);
	endtask : rate
	// Both-edge and falling-edge external counting, then the system clock and every divided rate
	task automatic t_rates();
		apb(1, OFS_PORT, 0);
		apb(1, OFS_CLKSEL, {27'h0, EDGE_BOTH, SRC_EXT});
		apb(1, OFS_COUNT, 0);
		apb(1, OFS_START, 3);
		repeat (3) begin
			cyc(3);
			ext_drv <= ~ext_drv;
		end
		cyc(4);
		apb(0, OFS_COUNT, 0);
		check(rdata, 3);
		apb(1, OFS_CLKSEL, {27'h0, EDGE_FALL, SRC_EXT});
		repeat (2) begin
			cyc(3);
			ext_drv <= ~ext_drv;
		end
		cyc(4);
		apb(0, OFS_COUNT, 0);
		check(rdata, 4);
		rate(SRC_SYSTEM_CLOCK, 32);
		rate(SRC_DIV2, 16);
		rate(SRC_DIV4, 8);
		rate(SRC_DIV8, 4);
		rate(SRC_DIV32, 1);
		apb(1, OFS_START, 2);
	endtask : t_rates
	task automatic t_strap();
		timer_clock_enable <= 1'b0;
		do_reset(1'b0, OSC_32MHZ);
		timer_clock_enable <= 1'b1;
		check(ihs_div_by_two, 0);
		apb(1, OFS_CLKSEL, SRC_HOCO);
		apb(1, OFS_START, 3);
		cyc(10);
		apb(0, OFS_COUNT, 0);
		check(rdata, 0);
		do_reset(1'b1, OSC_48MHZ);
		apb(1, OFS_CLKSEL, SRC_HOCO);
		apb(1, OFS_START, 3);
		cyc(10);
		apb(0, OFS_COUNT, 0);
		check(rdata != 0, 1);
	endtask : t_strap

	// ==========================================================
	// Clock and main sequence
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, ext_drv, timer_clock_enable} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		do_reset(1'b1, OSC_64MHZ);
		t_reset();
		t_wave();
		t_selfstop();
		t_irq();
		t_ext();
		t_rates();
		t_strap();
		report_and_stop();
	end
endmodule : reset_sync_pwm_timer_test

// >>> bench/rsp_timer_props.sv
// Port-level checker for the reset-synchronous PWM timer.
`timescale 1ns/1ps
module rsp_timer_props
	import rsp_timer_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Straps and pins
	input wire logic [1:0] osc_freq_code,
	input wire logic ihs_div_by_two,
	input wire logic pin_a_ch0_oe,
	input wire pwm_pins_s pwm_pins,
	input wire logic irq
);
	logic wr;
	logic stopped;
	logic sel_sh;
	logic [1:0] idle_sh;
	logic [1:0] quiet;
	logic [1:0] since_rst;
	logic [4:0] mask_sh;
	logic [2:0] src_sh;
	assign wr = psel && penable && pready && pwrite;

	// ==========================================================
	// Shadows of control writes; the self-stop cannot be seen here, so it is not tracked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stopped <= 1'b1;
			sel_sh <= 1'b0;
			idle_sh <= 2'b00;
			quiet <= 2'd0;
			since_rst <= 2'd0;
			mask_sh <= 5'h00;
			src_sh <= SRC_SYSTEM_CLOCK;
		end else begin
			since_rst <= (since_rst == 2'd3) ? 2'd3 : since_rst + 2'd1;
			quiet <= (quiet == 2'd3) ? 2'd3 : quiet + 2'd1;
			if (wr && (paddr == OFS_START || paddr == OFS_FUNC)) begin
				quiet <= 2'd0;
			end
			if (wr && paddr == OFS_START) begin
				sel_sh <= pwdata[START_SEL];
				if (pwdata[START_RUN]) begin
					stopped <= 1'b0;
				end else if (sel_sh) begin
					stopped <= 1'b1;
				end
			end
			if (wr && paddr == OFS_FUNC) begin
				idle_sh <= pwdata[1:0];
			end
			if (wr && paddr == OFS_MASK) begin
				mask_sh <= pwdata[4:0];
			end
			if (wr && paddr == OFS_CLKSEL) begin
				src_sh <= pwdata[2:0];
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > OFS_PORT))
		else $error("slave error wrong for address");
	AST_READ_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	AST_IDLE_STOP: assert property (stopped && quiet == 2'd3 |-> pwm_pins ==
		{idle_sh[0], idle_sh[0], idle_sh[1], idle_sh[0], idle_sh[0], idle_sh[1], idle_sh[1]})
		else $error("pins not idle while stopped");
	AST_IRQ_MASK: assert property (mask_sh == 5'h00 && $past(mask_sh) == 5'h00 |-> !irq)
		else $error("interrupt with all sources masked");
	AST_EXT_NO_DRIVE: assert property (src_sh == SRC_EXT && $past(src_sh) == SRC_EXT |-> !pin_a_ch0_oe)
		else $error("clock pin driven in external mode");
	AST_DIV_STRAP: assert property (since_rst == 2'd3 |-> ihs_div_by_two == !osc_freq_code[1])
		else $error("divide flag disagrees with strap");
endmodule : rsp_timer_props

bind reset_sync_pwm_timer rsp_timer_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_freq_code(osc_freq_code),
	.ihs_div_by_two(ihs_div_by_two), .pin_a_ch0_oe(pin_a_ch0_oe), .pwm_pins(pwm_pins),
	.irq(irq));

// >>> design/count_source.sv
// Count source selector producing one tick per count edge.
`timescale 1ns/1ps
module count_source
	import rsp_timer_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Selection
	input wire logic [2:0] source_select,
	input wire logic [1:0] ext_edge,
	input wire logic hoco_offered,
	input wire logic enable,
	// External count clock pin sample
	input wire logic external_count_clock,
	// Count edge
	output logic tick
);

	logic [4:0] div;
	logic ext_prev;
	logic ext_rise;
	logic ext_fall;

	// ==========================================================
	// Free-running prescaler, its low bits give the divided rates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 5'h00;
		end else begin
			div <= div + 5'h01;
		end
	end

	// Previous pin level for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= external_count_clock;
		end
	end

	assign ext_rise = external_count_clock & ~ext_prev;
	assign ext_fall = ~external_count_clock & ext_prev;

	// Tick selection; the oscillator source runs at full rate here
	always_comb begin
		tick = 1'b0;
		case (source_select)
			SRC_SYSTEM_CLOCK: tick = 1'b1;
			SRC_DIV2: tick = (div[0:0] == 1'h1);
			SRC_DIV4: tick = (div[1:0] == 2'h3);
			SRC_DIV8: tick = (div[2:0] == 3'h7);
			SRC_DIV32: tick = (div == 5'h1F);
			SRC_HOCO: tick = hoco_offered;
			SRC_EXT: begin
				case (ext_edge)
					EDGE_RISE: tick = ext_rise;
					EDGE_FALL: tick = ext_fall;
					EDGE_BOTH: tick = ext_rise | ext_fall;
					default: tick = 1'b0;
				endcase
			end
			default: tick = 1'b0;
		endcase
		tick = tick & enable;
	end

endmodule : count_source

// >>> design/reset_sync_pwm_timer.sv
// Reset-synchronous three-phase PWM timer with APB register access.
// Overview of operation
// - Oscillator count source works only when the frequency-select strap is one.
// - Internal clock is oscillator halved at 64/48 MHz, equal otherwise.
// - With stop-select one, counting stops only on writing run bit zero.
// - When stopped, all PWM pins show the programmed idle levels.
// - With stop-select zero, counting stops itself at period match.
// - Interrupt event on every period or duty compare match.
// - Interrupt event when the counter wraps past its maximum.
// - Channel-0 A pin is a plain port or the external clock input.
// - Channel-0 B pin carries channel one normal phase.
// - Period m+1 counts; normal active m-n, counter-phase inactive n+1.
// - Only counter zero counts, one step per count edge.
// - Channel-0 C pin toggles once every PWM period.
// - Remaining pins carry counter phases and channels two and three.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module reset_sync_pwm_timer
	import rsp_timer_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System clock control and straps
	input wire logic timer_clock_enable,
	input wire logic osc_freq_select_bit,
	input wire logic [1:0] osc_freq_code,
	output logic ihs_div_by_two,
	// Channel-0 A pin as port or clock input
	input wire logic pin_a_ch0_in,
	output logic pin_a_ch0_out,
	output logic pin_a_ch0_oe,
	// PWM pins
	output pwm_pins_s pwm_pins,
	// Interrupt
	output logic irq
);

	run_state_e state;
	logic stop_select;
	logic normal_phase_idle_level;
	logic counter_phase_idle_level;
	logic [2:0] source_select;
	logic [1:0] ext_edge;
	logic [15:0] period_compare;
	logic [15:0] duty_compare_ch1;
	logic [15:0] duty_compare_ch2;
	logic [15:0] duty_compare_ch3;
	logic [15:0] counter_zero;
	logic [EVT_BITS-1:0] status;
	logic [EVT_BITS-1:0] mask;
	logic [EVT_BITS-1:0] events;
	logic port_out;
	logic port_oe;
	logic strap_taken;
	logic hoco_offered;
	logic [2:0] active;
	logic toggle;
	logic tick;
	logic running;
	logic step;
	logic period_hit;
	logic auto_stop;
	logic ext_mode;
	logic setup;
	logic wr;
	logic [31:0] next_rdata;
	logic next_err;

	// Equality of counter against one compare register
	function automatic logic hit(input logic [15:0] cnt, input logic [15:0] val);
		hit = (cnt == val);
	endfunction : hit

	// Write strobe for one register offset
	function automatic logic wr_at(input logic w, input logic [11:0] a, input logic [11:0] o);
		wr_at = w & (a == o);
	endfunction : wr_at

	// ==========================================================
	// APB handshake
	assign setup = psel & ~penable;
	assign wr = psel & penable & pready & pwrite;

	// Read data mux, evaluated in the setup cycle
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr)
			OFS_START: next_rdata = {30'h0, stop_select, running};
			OFS_FUNC: next_rdata = {30'h0, counter_phase_idle_level, normal_phase_idle_level};
			OFS_CLKSEL: next_rdata = {27'h0, ext_edge, source_select};
			OFS_PERIOD: next_rdata = {16'h0, period_compare};
			OFS_DUTY1: next_rdata = {16'h0, duty_compare_ch1};
			OFS_DUTY2: next_rdata = {16'h0, duty_compare_ch2};
			OFS_DUTY3: next_rdata = {16'h0, duty_compare_ch3};
			OFS_COUNT: next_rdata = {16'h0, counter_zero};
			OFS_STATUS: next_rdata = {27'h0, status};
			OFS_MASK: next_rdata = {27'h0, mask};
			OFS_INFO: next_rdata = {29'h0, running, hoco_offered, ihs_div_by_two};
			OFS_PORT: next_rdata = {29'h0, pin_a_ch0_in, port_oe, port_out};
			default: next_err = 1'b1;
		endcase
	end

	// Zero-wait answer: ready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
			end else if (pready) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Straps caught on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_taken <= 1'b0;
			hoco_offered <= 1'b0;
			ihs_div_by_two <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			hoco_offered <= osc_freq_select_bit;
			ihs_div_by_two <= (osc_freq_code == OSC_64MHZ) |
				(osc_freq_code == OSC_48MHZ);
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			normal_phase_idle_level <= 1'b0;
			counter_phase_idle_level <= 1'b0;
			source_select <= SRC_SYSTEM_CLOCK;
			ext_edge <= EDGE_RISE;
			mask <= '0;
			port_out <= 1'b0;
			port_oe <= 1'b0;
		end else begin
			if (wr_at(wr, paddr, OFS_FUNC)) begin
				normal_phase_idle_level <= pwdata[FUNC_NIDLE];
				counter_phase_idle_level <= pwdata[FUNC_CIDLE];
			end
			if (wr_at(wr, paddr, OFS_CLKSEL)) begin
				source_select <= pwdata[2:0];
				ext_edge <= pwdata[4:3];
			end
			if (wr_at(wr, paddr, OFS_MASK)) begin
				mask <= pwdata[EVT_BITS-1:0];
			end
			if (wr_at(wr, paddr, OFS_PORT)) begin
				port_out <= pwdata[PORT_OUT];
				port_oe <= pwdata[PORT_OE];
			end
		end
	end

	// Compare registers; new values take effect at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_compare <= PERIOD_RST;
			duty_compare_ch1 <= DUTY_RST;
			duty_compare_ch2 <= DUTY_RST;
			duty_compare_ch3 <= DUTY_RST;
		end else begin
			if (wr_at(wr, paddr, OFS_PERIOD)) begin
				period_compare <= pwdata[15:0];
			end
			if (wr_at(wr, paddr, OFS_DUTY1)) begin
				duty_compare_ch1 <= pwdata[15:0];
			end
			if (wr_at(wr, paddr, OFS_DUTY2)) begin
				duty_compare_ch2 <= pwdata[15:0];
			end
			if (wr_at(wr, paddr, OFS_DUTY3)) begin
				duty_compare_ch3 <= pwdata[15:0];
			end
		end
	end

	// ==========================================================
	// Count edge generation; gated off while the peripheral clock is off
	assign ext_mode = (source_select == SRC_EXT);

	count_source u_count_source (
		.pclk(pclk),
		.presetn(presetn),
		.source_select(source_select),
		.ext_edge(ext_edge),
		.hoco_offered(hoco_offered),
		.enable(timer_clock_enable),
		.external_count_clock(pin_a_ch0_in),
		.tick(tick)
	);

	assign running = (state == ST_RUN);
	assign step = running & tick;
	assign period_hit = hit(counter_zero, period_compare);
	assign auto_stop = step & period_hit & ~stop_select;

	// ==========================================================
	// Run state; a software start in the same cycle beats the self-stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			stop_select <= 1'b0;
		end else begin
			if (wr_at(wr, paddr, OFS_START)) begin
				stop_select <= pwdata[START_SEL];
			end
			case (state)
				ST_IDLE: begin
					if (wr_at(wr, paddr, OFS_START) & pwdata[START_RUN]) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (wr_at(wr, paddr, OFS_START) & pwdata[START_RUN]) begin
						state <= ST_RUN;
					end else if (wr_at(wr, paddr, OFS_START) & stop_select) begin
						state <= ST_IDLE;
					end else if (auto_stop) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Counter zero; the second counter of the pair is not built in this mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_zero <= 16'h0000;
		end else if (wr_at(wr, paddr, OFS_COUNT)) begin
			counter_zero <= pwdata[15:0];
		end else if (step) begin
			if (period_hit) begin
				counter_zero <= 16'h0000;
			end else begin
				counter_zero <= counter_zero + 16'h0001;
			end
		end
	end

	// Phase state: active after duty match until the period ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active <= 3'h0;
			toggle <= 1'b0;
		end else if (!running) begin
			active <= 3'h0;
			toggle <= 1'b0;
		end else if (step) begin
			if (period_hit) begin
				active <= 3'h0;
				toggle <= ~toggle;
			end else begin
				// Duty match raises the phase for the rest of the period
				if (hit(counter_zero, duty_compare_ch1)) begin
					active[0] <= 1'b1;
				end
				if (hit(counter_zero, duty_compare_ch2)) begin
					active[1] <= 1'b1;
				end
				if (hit(counter_zero, duty_compare_ch3)) begin
					active[2] <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Pin drivers, one cycle behind the phase state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_pins <= '0;
		end else if (!running) begin
			// Idle levels also cover the period-match stop
			pwm_pins.pin_b_ch0 <= normal_phase_idle_level;
			pwm_pins.pin_c_ch0 <= normal_phase_idle_level;
			pwm_pins.pin_d_ch0 <= counter_phase_idle_level;
			pwm_pins.pin_a_ch1 <= normal_phase_idle_level;
			pwm_pins.pin_b_ch1 <= normal_phase_idle_level;
			pwm_pins.pin_c_ch1 <= counter_phase_idle_level;
			pwm_pins.pin_d_ch1 <= counter_phase_idle_level;
		end else begin
			pwm_pins.pin_b_ch0 <= normal_phase_idle_level ^ active[0];
			pwm_pins.pin_d_ch0 <= counter_phase_idle_level ^ active[0];
			pwm_pins.pin_a_ch1 <= normal_phase_idle_level ^ active[1];
			pwm_pins.pin_c_ch1 <= counter_phase_idle_level ^ active[1];
			pwm_pins.pin_b_ch1 <= normal_phase_idle_level ^ active[2];
			pwm_pins.pin_d_ch1 <= counter_phase_idle_level ^ active[2];
			pwm_pins.pin_c_ch0 <= normal_phase_idle_level ^ toggle;
		end
	end

	// Channel-0 A pin; drive is off from the cycle after it becomes the clock input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_ch0_out <= 1'b0;
			pin_a_ch0_oe <= 1'b0;
		end else begin
			pin_a_ch0_out <= port_out;
			pin_a_ch0_oe <= port_oe & ~ext_mode;
		end
	end

	// ==========================================================
	// Interrupt events
	always_comb begin
		events = '0;
		events[EVT_PERIOD] = step & period_hit;
		events[EVT_DUTY1] = step & hit(counter_zero, duty_compare_ch1);
		events[EVT_DUTY2] = step & hit(counter_zero, duty_compare_ch2);
		events[EVT_DUTY3] = step & hit(counter_zero, duty_compare_ch3);
		events[EVT_OVF] = step & ~period_hit & (counter_zero == COUNT_MAX);
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else if (wr_at(wr, paddr, OFS_STATUS)) begin
			status <= (status & ~pwdata[EVT_BITS-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

endmodule : reset_sync_pwm_timer

// >>> design/rsp_timer_pkg.sv
// Shared constants, types and register map of the reset-synchronous PWM timer.
package rsp_timer_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_START = 12'h000;
	localparam logic [11:0] OFS_FUNC = 12'h004;
	localparam logic [11:0] OFS_CLKSEL = 12'h008;
	localparam logic [11:0] OFS_PERIOD = 12'h00C;
	localparam logic [11:0] OFS_DUTY1 = 12'h010;
	localparam logic [11:0] OFS_DUTY2 = 12'h014;
	localparam logic [11:0] OFS_DUTY3 = 12'h018;
	localparam logic [11:0] OFS_COUNT = 12'h01C;
	localparam logic [11:0] OFS_STATUS = 12'h020;
	localparam logic [11:0] OFS_MASK = 12'h024;
	localparam logic [11:0] OFS_INFO = 12'h028;
	localparam logic [11:0] OFS_PORT = 12'h02C;

	// ==========================================================
	// Field positions
	localparam int START_RUN = 0;
	localparam int START_SEL = 1;
	localparam int FUNC_NIDLE = 0;
	localparam int FUNC_CIDLE = 1;
	localparam int EVT_PERIOD = 0;
	localparam int EVT_DUTY1 = 1;
	localparam int EVT_DUTY2 = 2;
	localparam int EVT_DUTY3 = 3;
	localparam int EVT_OVF = 4;
	localparam int EVT_BITS = 5;
	localparam int INFO_DIV2 = 0;
	localparam int INFO_HOCO = 1;
	localparam int INFO_RUN = 2;
	localparam int PORT_OUT = 0;
	localparam int PORT_OE = 1;
	localparam int PORT_IN = 2;

	// ==========================================================
	// Reset values and counter maximum
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

	// ==========================================================
	// Count source selection and external edge choice
	localparam logic [2:0] SRC_SYSTEM_CLOCK = 3'h0;
	localparam logic [2:0] SRC_DIV2 = 3'h1;
	localparam logic [2:0] SRC_DIV4 = 3'h2;
	localparam logic [2:0] SRC_DIV8 = 3'h3;
	localparam logic [2:0] SRC_DIV32 = 3'h4;
	localparam logic [2:0] SRC_HOCO = 3'h5;
	localparam logic [2:0] SRC_EXT = 3'h6;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// Oscillator frequency codes
	localparam logic [1:0] OSC_64MHZ = 2'h0;
	localparam logic [1:0] OSC_48MHZ = 2'h1;
	localparam logic [1:0] OSC_32MHZ = 2'h2;
	localparam logic [1:0] OSC_BELOW = 2'h3;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_e;

	typedef struct packed {
		logic pin_b_ch0;
		logic pin_c_ch0;
		logic pin_d_ch0;
		logic pin_a_ch1;
		logic pin_b_ch1;
		logic pin_c_ch1;
		logic pin_d_ch1;
	} pwm_pins_s;

endpackage : rsp_timer_pkg
